// ---- hdl/wk_cfg.svh ----
// Register offsets, field positions and reset values of the wakeup slave
`ifndef WK_CFG_SVH
`define WK_CFG_SVH

// Register byte offsets
`define WK_OFF_CTRL      8'h00
`define WK_OFF_ADDR      8'h04
`define WK_OFF_MASK      8'h08
`define WK_OFF_STAT      8'h0C
`define WK_OFF_IEN       8'h10
`define WK_OFF_CMD       8'h14
`define WK_OFF_STATE     8'h18

// CTRL fields
`define WK_CTRL_EN       0
`define WK_CTRL_DEEP     1
`define WK_CTRL_STRETCH  2

// STAT and IEN fields
`define WK_EV_ADDR       0
`define WK_EV_WAKE       1
`define WK_EV_STOP       2
`define WK_EV_W          3

// CMD fields
`define WK_CMD_ACK       0
`define WK_CMD_NAK       1

// STATE fields
`define WK_ST_BUSY       0
`define WK_ST_HOLD       1
`define WK_ST_LOCK       2
`define WK_ST_ARMED      3
`define WK_ST_BYTE_LSB   8

// Reset values
`define WK_RST_CTRL      3'h0
`define WK_RST_ADDR      7'h00
`define WK_RST_MASK      7'h7F
`define WK_RST_IEN       3'h0

// Address byte holds seven address bits and the direction bit
`define WK_BYTE_BITS     4'h8

`endif

// ---- hdl/wk_pkg.sv ----
// Types shared by the wakeup slave modules
package wk_pkg;

    typedef enum logic [2:0] {
        WK_IDLE,
        WK_ADDR,
        WK_HOLD,
        WK_ACK,
        WK_NAK,
        WK_DATA
    } wk_state_t;

endpackage : wk_pkg

// ---- hdl/wk_bus_if.sv ----
// Sampled bus events and address byte passed between the slave modules
`timescale 1ns/1ps
`default_nettype none

interface wk_bus_if;
    logic       scl_s;
    logic       sda_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start;
    logic       stop;
    logic [6:0] own_addr;
    logic [6:0] addr_mask;
    logic [7:0] addr_byte;
    logic       addr_full;
    logic       match;

    modport sync (output scl_s, sda_s, scl_rise, scl_fall, start, stop);
    modport matcher (input scl_s, sda_s, scl_rise, start, own_addr, addr_mask,
                     output addr_byte, addr_full, match);
    modport ctrl (input scl_s, sda_s, scl_rise, scl_fall, start, stop, addr_byte, addr_full, match,
                  output own_addr, addr_mask);
endinterface : wk_bus_if

`default_nettype wire

// ---- hdl/wk_pin_sync.sv ----
// Pin synchronisers and bus edge, start and stop detection
`timescale 1ns/1ps
`default_nettype none

module wk_pin_sync (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Bus pins
    input  wire logic scl_in,
    input  wire logic sda_in,
    // Sampled events
    wk_bus_if.sync    bus
);

    logic [1:0] scl_meta_q;
    logic [1:0] sda_meta_q;
    logic       scl_prev_q;
    logic       sda_prev_q;

    // Only the second stage and later are read by any logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_meta_q <= 2'h3;
            sda_meta_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_meta_q <= {scl_meta_q[0], scl_in};
            sda_meta_q <= {sda_meta_q[0], sda_in};
            scl_prev_q <= scl_meta_q[1];
            sda_prev_q <= sda_meta_q[1];
        end
    end

    assign bus.scl_s    = scl_meta_q[1];
    assign bus.sda_s    = sda_meta_q[1];
    assign bus.scl_rise = scl_meta_q[1] & ~scl_prev_q;
    assign bus.scl_fall = ~scl_meta_q[1] & scl_prev_q;
    // Data moving while the clock line is high marks a start or a stop
    assign bus.start    = scl_meta_q[1] & scl_prev_q & sda_prev_q & ~sda_meta_q[1];
    assign bus.stop     = scl_meta_q[1] & scl_prev_q & ~sda_prev_q & sda_meta_q[1];

endmodule : wk_pin_sync

`default_nettype wire

// ---- hdl/wk_addr_match.sv ----
// Address byte shifter and masked address compare
`timescale 1ns/1ps
`default_nettype none
`include "wk_cfg.svh"

module wk_addr_match (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Bus events and compare result
    wk_bus_if.matcher bus
);

    logic [7:0] shift_q;
    logic [3:0] count_q;
    logic       full;

    // A mask bit of zero makes that address bit a don't-care
    function automatic logic masked_hit(input logic [6:0] addr, input logic [6:0] own,
                                        input logic [6:0] mask);
        masked_hit = ((addr ^ own) & mask) == 7'h00;
    endfunction : masked_hit

    assign full = (count_q == `WK_BYTE_BITS);

    // Bits are taken with pclk at detected bus clock rises, so the compare needs pclk running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_q <= 8'h00;
            count_q <= 4'h0;
        end else if (bus.start) begin
            count_q <= 4'h0;
        end else if (bus.scl_rise && !full) begin
            shift_q <= {shift_q[6:0], bus.sda_s};
            count_q <= count_q + 4'h1;
        end
    end

    assign bus.addr_byte = shift_q;
    assign bus.addr_full = full;
    assign bus.match     = masked_hit(shift_q[7:1], bus.own_addr, bus.addr_mask);

endmodule : wk_addr_match

`default_nettype wire

// ---- hdl/wk_wake_top.sv ----
// Address-match wakeup slave: APB registers, answer sequencer and interrupt
// Notes on behaviour
// - In light sleep the block runs as in active mode and any transfer addressed to it raises an interrupt.
// - In deep sleep only a match of the bus address with the own address under the mask can raise a wakeup interrupt.
// - In deep sleep the address is shifted in with pclk at detected bus clock rises and a match raises an interrupt request.
// - With stretching on, a deep-sleep match holds the bus clock low until software orders the acknowledge or the refusal.
// - With stretching off, a deep-sleep match and every later address are refused until software wakes the block.
// - Extra addresses that pass the masked compare still wake the block and are answered exactly as the own address is.
// - Entering wakeup configuration arms the sampling of the address-match event.
// - The compare uses a mask whose zero bits are don't-care, so n such bits match 2^n addresses.
//
// The register offsets and the APB register port were decided locally.
`include "wk_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module wk_wake_top (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Bus clock pin
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe_n,
    // Bus data pin
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    // Interrupt
    output logic             irq
);

    wk_bus_if bus ();

    wk_pin_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .bus     (bus)
    );

    wk_addr_match u_match (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (bus)
    );

    // Register state
    logic [2:0]        ctrl_q;
    logic [6:0]        addr_q;
    logic [6:0]        mask_q;
    logic [2:0]        stat_q;
    logic [2:0]        stat_d;
    logic [2:0]        ien_q;
    logic [31:0]       prdata_q;
    wk_pkg::wk_state_t state_q;
    wk_pkg::wk_state_t state_d;
    logic              busy_q;
    logic              lock_q;
    logic              armed_q;
    logic              deep_prev_q;
    logic              sda_drive_q;
    logic              scl_drive_q;

    // APB decode
    logic        setup;
    logic        access;
    logic        wr;
    logic        sel_ctrl;
    logic        sel_addr;
    logic        sel_mask;
    logic        sel_stat;
    logic        sel_ien;
    logic        sel_cmd;
    logic        sel_state;
    logic        hit;
    logic [31:0] rd_mux;

    assign setup     = psel & ~penable;
    assign access    = psel & penable;
    assign wr        = access & pwrite;
    assign sel_ctrl  = (paddr == `WK_OFF_CTRL);
    assign sel_addr  = (paddr == `WK_OFF_ADDR);
    assign sel_mask  = (paddr == `WK_OFF_MASK);
    assign sel_stat  = (paddr == `WK_OFF_STAT);
    assign sel_ien   = (paddr == `WK_OFF_IEN);
    assign sel_cmd   = (paddr == `WK_OFF_CMD);
    assign sel_state = (paddr == `WK_OFF_STATE);
    assign hit       = sel_ctrl | sel_addr | sel_mask | sel_stat | sel_ien | sel_cmd | sel_state;

    // Control fields
    logic en;
    logic deep;
    logic stretch;

    assign en      = ctrl_q[`WK_CTRL_EN];
    assign deep    = ctrl_q[`WK_CTRL_DEEP];
    assign stretch = ctrl_q[`WK_CTRL_STRETCH];

    // Command strobes, only meaningful while the clock line is held
    logic cmd_ack;
    logic cmd_nak;

    assign cmd_ack = wr & sel_cmd & pwdata[`WK_CMD_ACK];
    assign cmd_nak = wr & sel_cmd & pwdata[`WK_CMD_NAK] & ~pwdata[`WK_CMD_ACK];

    assign bus.own_addr  = addr_q;
    assign bus.addr_mask = mask_q;

    // Address decision at the falling clock edge that ends the address byte
    logic decide;
    logic addr_hit;
    logic deep_wake;
    logic active_hit;

    assign decide     = (state_q == wk_pkg::WK_ADDR) & bus.addr_full & bus.scl_fall;
    assign addr_hit   = decide & bus.match;
    assign deep_wake  = addr_hit & deep & armed_q;
    assign active_hit = addr_hit & ~deep;

    // Sticky events: set wins over a same-cycle write-one clear
    logic [2:0] ev_set;
    logic [2:0] ev_clr;

    assign ev_set[`WK_EV_ADDR] = active_hit;
    assign ev_set[`WK_EV_WAKE] = deep_wake;
    assign ev_set[`WK_EV_STOP] = bus.stop & busy_q & ~deep;
    assign ev_clr              = (wr & sel_stat) ? pwdata[2:0] : 3'h0;
    assign stat_d              = (stat_q & ~ev_clr) | ev_set;

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            wk_pkg::WK_IDLE: begin
                if (bus.start) begin
                    state_d = wk_pkg::WK_ADDR;
                end
            end
            wk_pkg::WK_ADDR: begin
                if (decide) begin
                    if (!bus.match) begin
                        state_d = wk_pkg::WK_NAK;
                    end else if (deep && !stretch) begin
                        state_d = wk_pkg::WK_NAK;
                    end else if (lock_q) begin
                        state_d = wk_pkg::WK_NAK;
                    end else if (stretch) begin
                        state_d = wk_pkg::WK_HOLD;
                    end else begin
                        state_d = wk_pkg::WK_ACK;
                    end
                end
            end
            wk_pkg::WK_HOLD: begin
                if (cmd_ack) begin
                    state_d = wk_pkg::WK_ACK;
                end else if (cmd_nak) begin
                    state_d = wk_pkg::WK_NAK;
                end
            end
            wk_pkg::WK_ACK: begin
                if (bus.scl_fall) begin
                    state_d = wk_pkg::WK_DATA;
                end
            end
            wk_pkg::WK_NAK: begin
                if (bus.scl_fall) begin
                    state_d = wk_pkg::WK_IDLE;
                end
            end
            wk_pkg::WK_DATA: begin
                state_d = wk_pkg::WK_DATA;
            end
            default: begin
                state_d = wk_pkg::WK_IDLE;
            end
        endcase
        // A repeated start or a stop ends any transfer, except while the clock is held
        if (state_q != wk_pkg::WK_HOLD) begin
            if (bus.start) begin
                state_d = wk_pkg::WK_ADDR;
            end else if (bus.stop) begin
                state_d = wk_pkg::WK_IDLE;
            end
        end
        if (!en) begin
            state_d = wk_pkg::WK_IDLE;
        end
    end

    // Sequencer and pin drive registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q     <= wk_pkg::WK_IDLE;
            sda_drive_q <= 1'b0;
            scl_drive_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            sda_drive_q <= (state_d == wk_pkg::WK_ACK);
            scl_drive_q <= (state_d == wk_pkg::WK_HOLD);
        end
    end

    // Busy covers any address-matched transfer, acknowledged or refused, until the bus ends it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
        end else if (!en || bus.stop) begin
            busy_q <= 1'b0;
        end else if (addr_hit || state_q == wk_pkg::WK_HOLD) begin
            busy_q <= 1'b1;
        end else if (bus.start && state_q != wk_pkg::WK_DATA) begin
            busy_q <= 1'b0;
        end
    end

    // Refusal lock after a deep-sleep match without stretching
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q <= 1'b0;
        end else if (deep_wake && !stretch) begin
            lock_q <= 1'b1;
        end else if (!deep) begin
            lock_q <= 1'b0;
        end
    end

    // Arming follows entry into wakeup configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            deep_prev_q <= 1'b0;
            armed_q     <= 1'b0;
        end else begin
            deep_prev_q <= deep;
            if (!deep) begin
                armed_q <= 1'b0;
            end else if (!deep_prev_q) begin
                armed_q <= 1'b1;
            end
        end
    end

    // Software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `WK_RST_CTRL;
            addr_q <= `WK_RST_ADDR;
            mask_q <= `WK_RST_MASK;
            ien_q  <= `WK_RST_IEN;
            stat_q <= 3'h0;
        end else begin
            stat_q <= stat_d;
            if (wr && sel_ctrl) begin
                ctrl_q <= pwdata[2:0];
            end
            if (wr && sel_addr) begin
                addr_q <= pwdata[6:0];
            end
            if (wr && sel_mask) begin
                mask_q <= pwdata[6:0];
            end
            if (wr && sel_ien) begin
                ien_q <= pwdata[2:0];
            end
        end
    end

    // Read data
    logic [31:0] state_word;

    assign state_word = {16'h0000, bus.addr_byte, 4'h0, armed_q, lock_q,
                         (state_q == wk_pkg::WK_HOLD), busy_q};

    assign rd_mux = sel_ctrl  ? {29'h0000_0000, ctrl_q} :
                    sel_addr  ? {25'h000_0000, addr_q} :
                    sel_mask  ? {25'h000_0000, mask_q} :
                    sel_stat  ? {29'h0000_0000, stat_q} :
                    sel_ien   ? {29'h0000_0000, ien_q} :
                    sel_state ? state_word :
                    32'h0000_0000;

    // Read data is captured in the setup cycle and held through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = access & ~hit;

    // Pins are open drain: only a low level is ever driven
    assign scl_out  = 1'b0;
    assign sda_out  = 1'b0;
    assign scl_oe_n = ~scl_drive_q;
    assign sda_oe_n = ~sda_drive_q;

    // Level interrupt while any enabled event stays pending
    assign irq = |(stat_q & ien_q);

endmodule : wk_wake_top

`default_nettype wire

// ---- dv/wk_wake_assertions.sv ----
// Port-level assertions for the address-match wakeup slave
`timescale 1ns/1ps
`default_nettype none
`include "wk_cfg.svh"

module wk_wake_assertions (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    // Bus pins
    input wire logic        scl_in,
    input wire logic        scl_oe_n,
    input wire logic        sda_oe_n,
    // Interrupt
    input wire logic        irq
);
    // Shadow of the mode bits, fed by the same writes the block sees
    logic [2:0] ctrl_q;
    wire logic  wr         = psel && penable && pwrite;
    wire logic  ctrl_wr    = wr && paddr == `WK_OFF_CTRL;
    wire logic  ack_cmd    = wr && paddr == `WK_OFF_CMD && pwdata[`WK_CMD_ACK];
    wire logic  no_stretch = ctrl_q[`WK_CTRL_EN] && ctrl_q[`WK_CTRL_DEEP] && !ctrl_q[`WK_CTRL_STRETCH];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 3'h0;
        end else if (ctrl_wr) begin
            ctrl_q <= pwdata[2:0];
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ack_low; $fell(sda_oe_n) |-> !$past(scl_in); endproperty
    a_ack_low: assert property (p_ack_low) else $error("ack driven while clock high");
    property p_ack_hold; !sda_oe_n && scl_in |=> !sda_oe_n; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ack dropped during high");
    property p_irq_clr; $fell(irq) |-> $past(wr); endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("irq fell without a write");
    property p_irq_sync; $rose(irq) && !$past(wr) |-> !$past(scl_in, 2); endproperty
    a_irq_sync: assert property (p_irq_sync) else $error("irq rose before clock fall synced");
    property p_str_low; $fell(scl_oe_n) |-> !$past(scl_in, 2); endproperty
    a_str_low: assert property (p_str_low) else $error("stretch began on a high clock");
    property p_str_hold; !scl_oe_n && !wr && !$past(wr) |=> !scl_oe_n; endproperty
    a_str_hold: assert property (p_str_hold) else $error("stretch released without a write");
    property p_str_rel; !scl_oe_n && ack_cmd |-> ##[1:2] (scl_oe_n && !sda_oe_n); endproperty
    a_str_rel: assert property (p_str_rel) else $error("ack command did not release");
    property p_nostretch; no_stretch |-> sda_oe_n; endproperty
    a_nostretch: assert property (p_nostretch) else $error("ack given in deep no-stretch");

    c_stretch: cover property ($fell(scl_oe_n));
    c_ack: cover property ($fell(sda_oe_n));
    c_irq: cover property ($rose(irq));
endmodule : wk_wake_assertions

bind wk_wake_top wk_wake_assertions wk_wake_assertions_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .scl_in(scl_in), .scl_oe_n(scl_oe_n),
    .sda_oe_n(sda_oe_n), .irq(irq)
);

`default_nettype wire

// ---- dv/wk_bm_model.sv ----
// Behavioural bus master pulling the open-drain clock and data wires
`timescale 1ns/1ps
`default_nettype none

module wk_bm_model (
    // Wire levels
    input  wire logic scl,
    input  wire logic sda,
    // Pulls, high lets the wire float up
    output logic      scl_m,
    output logic      sda_m
);
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end

    // Bounded wait so a slave stuck stretching cannot hang the run
    task automatic rise;
        int n;
        n = 0;
        scl_m = 1'b1;
        while (scl !== 1'b1 && n < 600) begin
            #50;
            n++;
        end
        #200;
    endtask : rise

    task automatic start;
        sda_m = 1'b0;
        #200;
        scl_m = 1'b0;
        #100;
    endtask : start

    task automatic stop;
        sda_m = 1'b0;
        #100;
        rise();
        sda_m = 1'b1;
        #200;
    endtask : stop

    // Eight bits MSB first; the answer is sampled late in the ninth high
    task automatic xfer(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_m = b[i];
            #100;
            rise();
            scl_m = 1'b0;
            #100;
        end
        sda_m = 1'b1;
        #100;
        rise();
        ack = !sda;
        scl_m = 1'b0;
        #100;
    endtask : xfer
endmodule : wk_bm_model

`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the wakeup slave
`timescale 1ns/1ps
`default_nettype none
`include "wk_cfg.svh"

`define CHK(nm, e, g) \
    tests_run++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("mismatch %s expected %0h seen %0h", nm, e, g); \
    end

module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic        scl_out, scl_oe_n, sda_out, sda_oe_n, scl_m, sda_m, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    int          bad_count, tests_run;
    logic [6:0]  addr_tab [5];
    logic        ack_tab [5];
    // Pull-ups: a wire is low while any party pulls it
    wire logic   scl_w = scl_m && (scl_oe_n || scl_out);
    wire logic   sda_w = sda_m && (sda_oe_n || sda_out);

    wk_wake_top wk_wake_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq)
    );
    wk_bm_model bm (.scl(scl_w), .sda(sda_w), .scl_m(scl_m), .sda_m(sda_m));

    always #25 pclk = ~pclk;

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a wait for the answer
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Extra edge so flags touched by the write have landed before checks
        @(posedge pclk);
    endtask : apb

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(nm, e, rd)
    endtask : rdc

    // One address byte; a non-zero cmd is the firmware answer to a stretch
    task automatic talk(input logic [6:0] a, input logic [1:0] cmd, input logic exp);
        int n;
        logic got;
        n = 0;
        // Bus wires move off the sampling edge of pclk
        @(posedge pclk);
        #10;
        bm.start();
        fork
            bm.xfer({a, 1'b0}, got);
            if (cmd != 2'b00) begin
                while (scl_oe_n !== 1'b0 && n < 600) begin
                    n++;
                    @(posedge pclk);
                end
                repeat (40) @(posedge pclk);
                `CHK("stretch held", 1'b0, scl_oe_n)
                apb(1'b1, `WK_OFF_CMD, {30'h0, cmd});
            end
        join
        bm.stop();
        `CHK("address answer", exp, got)
    endtask : talk

    task summarize;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    // Twelve bus transfers of a few microseconds each, with wide margin
    initial begin
        #2_000_000;
        bad_count++;
        summarize();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        bad_count = 0;
        tests_run = 0;
        addr_tab = '{7'h24, 7'h34, 7'h20, 7'h30, 7'h25};
        ack_tab = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        rdc("ctrl", `WK_OFF_CTRL, 32'h0000_0000);
        rdc("mask", `WK_OFF_MASK, 32'h0000_007F);
        rdc("ien", `WK_OFF_IEN, 32'h0000_0000);
        rdc("unmapped", 8'h40, 32'h0000_0000);
        `CHK("unmapped error", 1'b1, err)
        $display("test reset done");
        // Primary 0x24 and secondary 0x30 differ in two bits: four addresses pass
        apb(1'b1, `WK_OFF_ADDR, 32'h0000_0024);
        apb(1'b1, `WK_OFF_MASK, 32'h0000_006B);
        apb(1'b1, `WK_OFF_IEN, 32'h0000_0001);
        apb(1'b1, `WK_OFF_CTRL, 32'h0000_0001);
        for (int i = 0; i < 5; i++) begin
            talk(addr_tab[i], 2'b00, ack_tab[i]);
        end
        rdc("stat active", `WK_OFF_STAT, 32'h0000_0005);
        `CHK("irq active", 1'b1, irq)
        apb(1'b1, `WK_OFF_IEN, 32'h0000_0000);
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, `WK_OFF_STAT, 32'h0000_0007);
        rdc("stat cleared", `WK_OFF_STAT, 32'h0000_0000);
        $display("test active done");
        apb(1'b0, `WK_OFF_STATE, 32'h0000_0000);
        `CHK("idle before sleep", 1'b0, rd[`WK_ST_BUSY])
        apb(1'b1, `WK_OFF_IEN, 32'h0000_0002);
        apb(1'b1, `WK_OFF_CTRL, 32'h0000_0007);
        apb(1'b0, `WK_OFF_STATE, 32'h0000_0000);
        `CHK("armed", 1'b1, rd[`WK_ST_ARMED])
        talk(7'h25, 2'b00, 1'b0);
        rdc("no wake", `WK_OFF_STAT, 32'h0000_0000);
        talk(7'h20, 2'b10, 1'b0);
        rdc("wake extra", `WK_OFF_STAT, 32'h0000_0002);
        `CHK("irq wake", 1'b1, irq)
        apb(1'b1, `WK_OFF_STAT, 32'h0000_0007);
        apb(1'b1, `WK_OFF_CTRL, 32'h0000_0005);
        // Active mode with stretching: firmware refuses an extra masked address
        talk(7'h34, 2'b10, 1'b0);
        rdc("stat stretch active", `WK_OFF_STAT, 32'h0000_0005);
        apb(1'b1, `WK_OFF_CTRL, 32'h0000_0007);
        talk(7'h30, 2'b01, 1'b1);
        apb(1'b1, `WK_OFF_STAT, 32'h0000_0007);
        `CHK("irq cleared", 1'b0, irq)
        $display("test deep stretch done");
        // Address match runs on pclk here, so the bench keeps it running through deep sleep
        apb(1'b1, `WK_OFF_CTRL, 32'h0000_0001);
        apb(1'b1, `WK_OFF_CTRL, 32'h0000_0003);
        talk(7'h24, 2'b00, 1'b0);
        `CHK("irq no stretch", 1'b1, irq)
        talk(7'h30, 2'b00, 1'b0);
        apb(1'b0, `WK_OFF_STATE, 32'h0000_0000);
        `CHK("lock", 1'b1, rd[`WK_ST_LOCK])
        apb(1'b1, `WK_OFF_CTRL, 32'h0000_0001);
        talk(7'h24, 2'b00, 1'b1);
        $display("test deep no stretch done");
        summarize();
    end
endmodule : tb

`default_nettype wire
